// ### logic/harmonic_overcurrent_stage.sv
// one harmonic overcurrent stage: pick-up, blocking, timing, status, events, counters, records
`timescale 1ns/1ns
// Overview of operation
// - any phase above the shared threshold causes pick-up
// - quantity is per unit or percent of fundamental, by mode
// - thresholds clamped to documented ranges, defaults 0.20 pu and 20.00 %
// - drop-out only below 97 % of the threshold
// - settings taken live each update without stopping the stage
// - blocking input sampled at start of each update
// - pick-up without block sets start and runs operate timer
// - pick-up with block sets blocked, no start or trip
// - block after start clears start and runs release timing
// - definite and inverse time delays for trip, definite delay only for reset
// - live condition normal, start, trip or blocked
// - live ratio measured over threshold, 0.01 steps
// - expected operate time, recomputed as magnitude changes
// - remaining time to trip while counting
// - on and off events, storage selected by configuration
// - each event carries its time stamp
// - resettable start, trip and blocked counters
// - four stage instances with own event identity
// - last twelve records, written on each on event
// - record holds stamp, name, phases, currents, remain, group
// - selectable harmonic order, default second
module harmonic_overcurrent_stage
	import hocs_pkg::*;
#(
	parameter logic [1:0] STAGE_ID = 2'h0,
	parameter int         UPD_CYC  = UPDATE_CYC
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     clk_en,
	input  wire hocs_phase_type [NPH-1:0] meas,
	input  wire hocs_cfg_type             cfg,
	input  wire logic                     block_in,
	input  wire logic [TS_W-1:0]          time_now,
	input  wire logic                     cnt_clear,
	input  wire logic [3:0]               rec_rd_addr,
	output logic                          start_out,
	output logic                          trip_out,
	output logic                          blocked_out,
	output hocs_cond_type                 condition,
	output logic [RATIO_W-1:0]            ratio_now,
	output logic [TIME_W-1:0]             expected_time,
	output logic [TIME_W:0]               remain_time,
	output hocs_event_type                event_out,
	output logic [15:0]                   start_count,
	output logic [15:0]                   trip_count,
	output logic [15:0]                   block_count,
	output hocs_record_type               rec_rd_data,
	output logic [3:0]                    rec_latest
);
	typedef struct packed {
		logic [31:0]                 tick;
		logic                        pick;
		logic                        start;
		logic                        trip;
		logic                        blocked;
		logic [TIME_W-1:0]           op_cnt;
		logic [TIME_W-1:0]           rel_cnt;
		hocs_cond_type               cond;
		logic [RATIO_W-1:0]          ratio;
		logic [TIME_W-1:0]           expect_t;
		logic [TIME_W:0]             remain;
		hocs_event_type              ev;
		logic [15:0]                 n_start;
		logic [15:0]                 n_trip;
		logic [15:0]                 n_block;
		logic [HIST_D-1:0][MAG_W-1:0] hist;
		logic [MAG_W-1:0]            start_mag;
		logic [3:0]                  wptr;
		logic [3:0]                  latest;
	} hocs_state_type;

	hocs_state_type  s_q;
	hocs_state_type  s_d;
	hocs_record_type rec_d;
	logic            rec_we;

	// clamp a threshold into its legal range
	function automatic logic [MAG_W-1:0] clamp(input logic [MAG_W-1:0] v, input logic [MAG_W-1:0] lo,
		input logic [MAG_W-1:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// comparison quantity for one phase
	function automatic logic [MAG_W-1:0] quantity(input hocs_phase_type p, input logic [HSEL_W-1:0] sel,
		input logic by_ratio);
		logic [MAG_W-1:0] h;
		logic [31:0]      q;
		h = (sel < HSEL_W'(NHARM)) ? p.harm[sel] : p.harm[0];
		q = '0;
		if (by_ratio) begin
			q = (p.fund == '0) ? 32'h0000FFFF : (32'(h) * 32'(PCT_SCALE)) / 32'(p.fund);
			return (q > 32'h0000FFFF) ? 16'hFFFF : q[MAG_W-1:0];
		end
		return h;
	endfunction

	// saturating counter increment
	function automatic logic [15:0] bump(input logic [15:0] c);
		return (c == 16'hFFFF) ? c : c + 16'h0001;
	endfunction

	// build an event word
	function automatic hocs_event_type mk_event(input hocs_evname_type n, input logic on,
		input logic [1:0] store, input logic [TS_W-1:0] ts);
		hocs_event_type e;
		e.valid = on ? store[0] : store[1];
		e.on    = on;
		e.name  = n;
		e.stage = STAGE_ID;
		e.stamp = ts;
		return e;
	endfunction

	logic [MAG_W-1:0]     thr;
	logic [MAG_W-1:0]     q [NPH];
	logic [NPH-1:0]       over;
	logic [NPH-1:0]       under;
	logic [MAG_W-1:0]     qmax;
	logic [TIME_W-1:0]    op_target;
	logic [TIME_W-1:0]    rel_target;
	logic                 upd;
	logic                 blk;
	logic                 pick_now;
	logic [31:0]          rr;

	// thresholds, quantities, pick-up with hysteresis
	always_comb begin
		thr = cfg.by_ratio ? clamp(cfg.thr_pct, PC_MIN, PC_MAX) : clamp(cfg.thr_pu, PU_MIN, PU_MAX);
		qmax = '0;
		for (int i = 0; i < NPH; i++) begin
			q[i] = quantity(meas[i], cfg.harm_sel, cfg.by_ratio);
			over[i] = q[i] > thr;
			under[i] = (32'(q[i]) * 32'(HUNDRED)) < (32'(thr) * 32'(RESET_PCT));
			if (q[i] > qmax) begin
				qmax = q[i];
			end
		end
		pick_now = s_q.pick ? ~(&under) : (|over);
		rr = (32'(qmax) * 32'(HUNDRED)) / 32'(thr);
		// inverse time shortens with the square of the ratio, floor one tick
		if (cfg.idmt && rr > 32'(HUNDRED)) begin
			op_target = TIME_W'((64'(cfg.op_delay) * 64'(HUNDRED) * 64'(HUNDRED)) / (64'(rr) * 64'(rr)));
			rel_target = cfg.rel_delay;
		end else begin
			op_target = cfg.op_delay;
			rel_target = cfg.rel_delay;
		end
		if (op_target > TIME_MAX) begin
			op_target = TIME_MAX;
		end
		if (op_target == '0) begin
			op_target = TIME_W'(1);
		end
	end

	assign upd = (s_q.tick == 32'(UPD_CYC - 1));
	assign blk = block_in;

	// next state: tick and counter clear every cycle, the rest once per update
	always_comb begin
		s_d = s_q;
		rec_we = 1'b0;
		rec_d = '0;
		s_d.ev.valid = 1'b0;
		s_d.tick = upd ? '0 : s_q.tick + 32'h1;
		if (cnt_clear) begin
			s_d.n_start = '0;
			s_d.n_trip = '0;
			s_d.n_block = '0;
		end
		if (upd) begin
			s_d.pick = pick_now;
			s_d.ratio = (rr > 32'h00989680) ? 24'h989680 : rr[RATIO_W-1:0];
			s_d.expect_t = op_target;
			s_d.hist = {s_q.hist[HIST_D-2:0], qmax};
			if (pick_now && blk) begin
				// blocked: start cleared, release timing applies
				if (!s_q.blocked) begin
					s_d.blocked = 1'b1;
					s_d.ev = mk_event(HOCS_EV_BLOCK, 1'b1, cfg.ev_store, time_now);
					s_d.n_block = bump(s_q.n_block);
					rec_we = 1'b1;
				end
				if (s_q.start) begin
					s_d.start = 1'b0;
					s_d.trip = 1'b0;
					s_d.rel_cnt = '0;
				end
			end else if (pick_now) begin
				s_d.blocked = 1'b0;
				s_d.rel_cnt = '0;
				if (!s_q.start) begin
					s_d.start = 1'b1;
					s_d.start_mag = qmax;
					s_d.ev = mk_event(HOCS_EV_START, 1'b1, cfg.ev_store, time_now);
					s_d.n_start = bump(s_q.n_start);
					rec_we = 1'b1;
				end else if (!s_q.trip) begin
					s_d.op_cnt = s_q.op_cnt + TIME_W'(1);
					if (s_d.op_cnt >= op_target) begin
						s_d.trip = 1'b1;
						s_d.ev = mk_event(HOCS_EV_TRIP, 1'b1, cfg.ev_store, time_now);
						s_d.n_trip = bump(s_q.n_trip);
						rec_we = 1'b1;
					end
				end
			end else begin
				// release timing after pick-up has ended
				if (s_q.blocked) begin
					s_d.blocked = 1'b0;
					s_d.ev = mk_event(HOCS_EV_BLOCK, 1'b0, cfg.ev_store, time_now);
				end
				if (s_q.start || s_q.trip) begin
					s_d.start = 1'b0;
					s_d.trip = 1'b0;
					s_d.ev = mk_event(s_q.trip ? HOCS_EV_TRIP : HOCS_EV_START, 1'b0, cfg.ev_store, time_now);
				end
				if (s_q.op_cnt != '0) begin
					s_d.rel_cnt = s_q.rel_cnt + TIME_W'(1);
					if (s_d.rel_cnt >= rel_target) begin
						s_d.op_cnt = '0;
						s_d.rel_cnt = '0;
					end
				end
			end
			if (pick_now && blk && s_q.op_cnt != '0) begin
				s_d.rel_cnt = s_q.rel_cnt + TIME_W'(1);
				if (s_d.rel_cnt >= rel_target) begin
					s_d.op_cnt = '0;
					s_d.rel_cnt = '0;
				end
			end
			s_d.remain = (s_d.start && !s_d.trip) ? {1'b0, op_target} - {1'b0, s_d.op_cnt} : '0;
			s_d.cond = s_d.trip ? HOCS_TRIP : s_d.start ? HOCS_START : s_d.blocked ? HOCS_BLOCKED
				: HOCS_NORMAL;
			if (rec_we) begin
				// fault record for the on event
				rec_d.stamp = time_now;
				rec_d.name = s_d.ev.name;
				rec_d.phases = over;
				rec_d.pre_trig = s_q.hist[PRE_TRIG_T-1];
				rec_d.fault = qmax;
				rec_d.pre_fault = s_q.hist[PRE_FLT_T-1];
				rec_d.remain = s_d.remain[TIME_W-1:0];
				rec_d.group = cfg.group;
				s_d.latest = s_q.wptr;
				s_d.wptr = (s_q.wptr == 4'(NREC - 1)) ? '0 : s_q.wptr + 4'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	hocs_record_mem #(.DEPTH(NREC)) u_rec (
		.clock   (clock),
		.clk_en  (clk_en),
		.wr_en   (rec_we),
		.wr_addr (s_q.wptr),
		.wr_data (rec_d),
		.rd_addr (rec_rd_addr),
		.rd_data (rec_rd_data)
	);

	// outputs straight from state
	assign start_out     = s_q.start;
	assign trip_out      = s_q.trip;
	assign blocked_out   = s_q.blocked;
	assign condition     = s_q.cond;
	assign ratio_now     = s_q.ratio;
	assign expected_time = s_q.expect_t;
	assign remain_time   = s_q.remain;
	assign event_out     = s_q.ev;
	assign start_count   = s_q.n_start;
	assign trip_count    = s_q.n_trip;
	assign block_count   = s_q.n_block;
	assign rec_latest    = s_q.latest;
endmodule // harmonic_overcurrent_stage

// ### logic/hocs_pkg.sv
// shared constants and carrier types for the harmonic overcurrent stage
package hocs_pkg;
	localparam int MAG_W   = 16;  // magnitudes in 0.01 units
	localparam int HSEL_W  = 4;
	localparam int NPH     = 3;
	localparam int NSTAGE  = 4;
	localparam int NREC    = 12;
	localparam int TS_W    = 32;
	localparam int TIME_W  = 20;  // time in 5 ms ticks
	localparam int RATIO_W = 24;
	localparam int GRP_W   = 3;
	localparam int NHARM   = 13;
	// per unit threshold in 0.01 x nominal
	localparam logic [MAG_W-1:0] PU_MIN = 16'h0005;
	localparam logic [MAG_W-1:0] PU_MAX = 16'h00C8;
	localparam logic [MAG_W-1:0] PU_DEF = 16'h0014;
	// percentage threshold in 0.01 %
	localparam logic [MAG_W-1:0] PC_MIN = 16'h01F4;
	localparam logic [MAG_W-1:0] PC_MAX = 16'h4E20;
	localparam logic [MAG_W-1:0] PC_DEF = 16'h07D0;
	localparam logic [7:0]  RESET_PCT   = 8'h61;  // 97 percent drop-out
	localparam logic [7:0]  HUNDRED     = 8'h64;
	localparam logic [13:0] PCT_SCALE   = 14'h2710; // 100.00 % in 0.01 %
	localparam logic [HSEL_W-1:0] HSEL_DEF = 4'h0; // second harmonic
	localparam int UPDATE_MS   = 5;
	localparam int CLOCK_KHZ   = 25000;
	localparam int UPDATE_CYC  = UPDATE_MS * CLOCK_KHZ;
	localparam int TIME_MAX_S  = 1800;
	localparam logic [TIME_W-1:0] TIME_MAX = 20'h57E40; // 1800 s in 5 ms ticks
	localparam int PRE_TRIG_MS = 20;
	localparam int PRE_FLT_MS  = 200;
	localparam int PRE_TRIG_T  = PRE_TRIG_MS / UPDATE_MS;
	localparam int PRE_FLT_T   = PRE_FLT_MS / UPDATE_MS;
	localparam int HIST_D      = PRE_FLT_T + 1;

	typedef enum logic [1:0] {HOCS_NORMAL, HOCS_START, HOCS_TRIP, HOCS_BLOCKED} hocs_cond_type;
	typedef enum logic [1:0] {HOCS_EV_START, HOCS_EV_TRIP, HOCS_EV_BLOCK} hocs_evname_type;

	// measurement frame for one update
	typedef struct packed {
		logic [NHARM-1:0][MAG_W-1:0] harm;
		logic [MAG_W-1:0]            fund;
	} hocs_phase_type;

	typedef struct packed {
		logic                       by_ratio;   // 1: percent of fundamental
		logic [HSEL_W-1:0]          harm_sel;
		logic [MAG_W-1:0]           thr_pu;
		logic [MAG_W-1:0]           thr_pct;
		logic                       idmt;
		logic [TIME_W-1:0]          op_delay;   // ticks, or multiplier for idmt
		logic [TIME_W-1:0]          rel_delay;
		logic [1:0]                 ev_store;   // bit0 on, bit1 off
		logic [GRP_W-1:0]           group;
	} hocs_cfg_type;

	typedef struct packed {
		logic                       valid;
		logic                       on;
		hocs_evname_type            name;
		logic [1:0]                 stage;
		logic [TS_W-1:0]            stamp;
	} hocs_event_type;

	typedef struct packed {
		logic [TS_W-1:0]            stamp;
		hocs_evname_type            name;
		logic [NPH-1:0]             phases;
		logic [MAG_W-1:0]           pre_trig;
		logic [MAG_W-1:0]           fault;
		logic [MAG_W-1:0]           pre_fault;
		logic [TIME_W-1:0]          remain;
		logic [GRP_W-1:0]           group;
	} hocs_record_type;
endpackage

// ### logic/hocs_record_mem.sv
// twelve-entry ring store of fault records with registered read
`timescale 1ns/1ns
module hocs_record_mem
	import hocs_pkg::*;
#(
	parameter int DEPTH = NREC
) (
	input  wire logic                     clock,
	input  wire logic                     clk_en,
	input  wire logic                     wr_en,
	input  wire logic [3:0]               wr_addr,
	input  wire hocs_record_type          wr_data,
	input  wire logic [3:0]               rd_addr,
	output hocs_record_type               rd_data
);
	hocs_record_type mem [DEPTH];

	// write port and registered read port
	always_ff @(posedge clock) begin
		if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // hocs_record_mem

// ### verif/hocs_front_model.sv
// measurement front end and blocking matrix model
`timescale 1ns/1ns
module hocs_front_model
	import hocs_pkg::*;
(
	input  wire logic                 blk_req,
	input  wire logic [HSEL_W-1:0]    hsel,
	input  wire logic [MAG_W-1:0]     fund,
	input  wire logic [MAG_W-1:0]     lvl [NPH],
	output hocs_phase_type [NPH-1:0]  meas,
	output logic                      block_out
);
	// unselected orders carry huge magnitudes so a wrong pick shows
	always_comb begin
		for (int p = 0; p < NPH; p++) begin
			for (int h = 0; h < NHARM; h++) begin
				meas[p].harm[h] = (h == hsel) ? lvl[p] : 16'hFFFF;
			end
			meas[p].fund = fund;
		end
	end
	// request passed straight through to the block input, no timing applied
	assign block_out = blk_req;
endmodule // hocs_front_model

// ### verif/harmonic_overcurrent_stage_asserts.sv
// concurrent checks on the stage ports
`timescale 1ns/1ns
module hocs_stage_asserts
	import hocs_pkg::*;
#(
	parameter logic [1:0] STAGE_ID = 2'h0
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              block_in,
	input wire logic [TS_W-1:0]   time_now,
	input wire logic              cnt_clear,
	input wire logic              start_out,
	input wire logic              trip_out,
	input wire logic              blocked_out,
	input wire hocs_cond_type     condition,
	input wire logic [TIME_W:0]   remain_time,
	input wire hocs_event_type    event_out,
	input wire logic [15:0]       start_count
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// output relations
	no_start_blk_a: assert property (!(start_out && blocked_out))
		else $error("start and blocked together");
	cond_map_a: assert property (condition == (blocked_out ? HOCS_BLOCKED : trip_out ? HOCS_TRIP :
		start_out ? HOCS_START : HOCS_NORMAL)) else $error("condition disagrees with outputs");
	evt_pulse_a: assert property (event_out.valid |=> !event_out.valid)
		else $error("event valid longer than one cycle");
	evt_stage_a: assert property (event_out.valid |-> event_out.stage == STAGE_ID)
		else $error("event stage wrong");
	evt_stamp_a: assert property (event_out.valid |-> event_out.stamp == $past(time_now))
		else $error("event stamp wrong");
	remain_idle_a: assert property ((!start_out || trip_out) |-> remain_time == '0)
		else $error("remaining time outside counting");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> condition == HOCS_NORMAL && !start_out)
		else $error("outputs not cleared by reset");
	start_hold_a: assert property ($rose(start_out) |-> start_out [*8])
		else $error("start changed between updates");
	start_cnt_a: assert property ($rose(start_out) && !$past(cnt_clear) |->
		start_count == $past(start_count) + 16'h0001) else $error("start counter not stepped");
	blk_cause_a: assert property ($rose(blocked_out) |-> $past(block_in))
		else $error("blocked without sampled block");
endmodule // hocs_stage_asserts
bind harmonic_overcurrent_stage hocs_stage_asserts #(.STAGE_ID(STAGE_ID)) u_chk (.clock(clock), .rst(rst),
	.block_in(block_in), .time_now(time_now), .cnt_clear(cnt_clear), .start_out(start_out),
	.trip_out(trip_out), .blocked_out(blocked_out), .condition(condition), .remain_time(remain_time),
	.event_out(event_out), .start_count(start_count));

// ### verif/harmonic_overcurrent_stage_test.sv
// self-checking bench for the harmonic overcurrent stage
`timescale 1ns/1ns
module harmonic_overcurrent_stage_test
	import hocs_pkg::*;
;
	logic clock, rst, blk_req, cnt_clear, block_in, start_out, trip_out, blocked_out;
	logic [MAG_W-1:0] lvl [NPH];
	logic [MAG_W-1:0] fund;
	hocs_cfg_type cfg;
	hocs_phase_type [NPH-1:0] meas;
	logic [TS_W-1:0] time_now;
	logic [3:0] rec_rd_addr, rec_latest;
	hocs_cond_type condition;
	logic [RATIO_W-1:0] ratio_now;
	logic [TIME_W-1:0] expected_time;
	logic [TIME_W:0] remain_time;
	hocs_event_type event_out;
	logic [15:0] start_count, trip_count, block_count;
	hocs_record_type rec_rd_data;
	int mismatches, n_checks;
	// far side and device
	hocs_front_model u_front (.blk_req(blk_req), .hsel(cfg.harm_sel), .fund(fund), .lvl(lvl), .meas(meas),
		.block_out(block_in));
	harmonic_overcurrent_stage #(.STAGE_ID(2'h0), .UPD_CYC(8)) u_dut (.clock(clock), .rst(rst),
		.clk_en(1'b1), .meas(meas), .cfg(cfg), .block_in(block_in), .time_now(time_now),
		.cnt_clear(cnt_clear), .rec_rd_addr(rec_rd_addr), .start_out(start_out), .trip_out(trip_out),
		.blocked_out(blocked_out), .condition(condition), .ratio_now(ratio_now),
		.expected_time(expected_time), .remain_time(remain_time), .event_out(event_out),
		.start_count(start_count), .trip_count(trip_count), .block_count(block_count),
		.rec_rd_data(rec_rd_data), .rec_latest(rec_latest));
	// clock and free-running stamp
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) time_now <= #1 time_now + 32'h1;
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// whole updates, keeping the mid-period phase
	task automatic upd(input int n);
		repeat (8 * n) @(posedge clock);
		#1;
	endtask
	task automatic t_pickup();
		cfg.thr_pu = 16'h0064;
		lvl[1] = 16'h0064;
		upd(1);
		chk(start_out, 1'b0);
		lvl[1] = 16'h0065;
		upd(1);
		chk(start_out, 1'b1);
		chk(ratio_now, 24'h000065);
		chk(remain_time, 24'h000003);
		chk(start_count, 24'h000001);
		chk(expected_time, 24'h000003);
		upd(2);
		chk(trip_out, 1'b0);
		upd(1);
		chk(trip_out, 1'b1);
		lvl[1] = 16'h0061;
		upd(1);
		chk(start_out, 1'b1);
		lvl[1] = 16'h0060;
		upd(1);
		chk(start_out, 1'b0);
		rec_rd_addr = rec_latest;
		upd(1);
		chk(rec_rd_data.name, HOCS_EV_TRIP);
		chk(rec_rd_data.group, cfg.group);
		lvl[1] = '0;
		upd(2);
	endtask
	task automatic t_block();
		blk_req = 1'b1;
		lvl[0] = 16'h0065;
		upd(1);
		chk(blocked_out, 1'b1);
		chk(block_count, 24'h000001);
		upd(5);
		chk(trip_out, 1'b0);
		blk_req = 1'b0;
		lvl[0] = '0;
		upd(2);
		chk(condition, HOCS_NORMAL);
		lvl[0] = 16'h0065;
		upd(1);
		chk(start_out, 1'b1);
		blk_req = 1'b1;
		upd(1);
		chk(start_out, 1'b0);
		upd(4);
		chk(trip_out, 1'b0);
		blk_req = 1'b0;
		lvl[0] = '0;
		upd(2);
	endtask
	task automatic t_ratio();
		cfg.by_ratio = 1'b1;
		fund = 16'h03E8;
		lvl[2] = 16'h00C8;
		upd(1);
		chk(start_out, 1'b0);
		lvl[2] = 16'h00C9;
		upd(1);
		chk(start_out, 1'b1);
		lvl[2] = '0;
		cfg.by_ratio = 1'b0;
		upd(2);
	endtask
	task automatic t_clamp_sel();
		cfg.thr_pu = 16'h0001;
		cfg.harm_sel = 4'h3;
		lvl[0] = 16'h0005;
		upd(1);
		chk(start_out, 1'b0);
		lvl[0] = 16'h0006;
		upd(1);
		chk(start_out, 1'b1);
		lvl[0] = '0;
		upd(2);
		cnt_clear = 1'b1;
		upd(1);
		cnt_clear = 1'b0;
		chk(start_count, 24'h000000);
		chk(trip_count, 24'h000000);
	endtask
	// inverse time: target shrinks with the square of the ratio
	task automatic t_idmt();
		cfg.idmt = 1'b1;
		cfg.op_delay = 20'h00010;
		cfg.thr_pu = 16'h0064;
		lvl[0] = 16'h00C8;
		upd(1);
		chk(start_out, 1'b1);
		chk(expected_time, 24'h000004);
		lvl[0] = 16'h0190;
		upd(1);
		chk(expected_time, 24'h000001);
		chk(trip_out, 1'b1);
		lvl[0] = '0;
		cfg.idmt = 1'b0;
		cfg.op_delay = 20'h00003;
		upd(2);
		chk(start_out, 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		blk_req = 1'b0;
		cnt_clear = 1'b0;
		time_now = '0;
		rec_rd_addr = 4'h0;
		fund = 16'h0064;
		lvl = '{default: 16'h0000};
		cfg = '{by_ratio: 1'b0, harm_sel: HSEL_DEF, thr_pu: PU_DEF, thr_pct: PC_DEF, idmt: 1'b0,
			op_delay: 20'h00003, rel_delay: 20'h00001, ev_store: 2'h3, group: 3'h1};
		repeat (4) @(posedge clock);
		#1 rst = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		t_pickup();
		t_block();
		t_ratio();
		t_clamp_sel();
		t_idmt();
		end_of_test();
	end
endmodule // harmonic_overcurrent_stage_test
